//--- hw/i2csp_map.svh
// register offsets, field positions, codes and reset values of the serial port
`ifndef I2CSP_MAP_SVH
`define I2CSP_MAP_SVH
// byte offsets on the register bus
`define I2CSP_OFS_CTRL     8'h00
`define I2CSP_OFS_STAT     8'h04
`define I2CSP_OFS_BUF      8'h08
`define I2CSP_OFS_ADDR     8'h0C
`define I2CSP_OFS_PDIR     8'h10
`define I2CSP_OFS_PIF      8'h14
// control field positions
`define I2CSP_CTRL_OV      6
`define I2CSP_CTRL_EN      5
`define I2CSP_CTRL_CLKREL  4
`define I2CSP_MODE_HI      3
// interrupt flag position
`define I2CSP_PIF_BIT      0
// pin direction positions, set means input
`define I2CSP_PDIR_SDA     1
`define I2CSP_PDIR_SCL     0
// mode select codes
`define I2CSP_MODE_S7      4'h6
`define I2CSP_MODE_S10     4'h7
`define I2CSP_MODE_MST     4'hB
`define I2CSP_MODE_S7I     4'hE
`define I2CSP_MODE_S10I    4'hF
// ten-bit header prefix
`define I2CSP_TEN_HDR      5'h1E
// bit counts of a byte
`define I2CSP_BYTE_BITS    4'h8
`define I2CSP_LAST_BIT     4'h7
// reset values
`define I2CSP_RST_PDIR     2'h3
`define I2CSP_LINE_IDLE    1'h1
// bus codes
`define I2CSP_HRESP_OKAY   1'h0
`endif

//--- hw/i2csp_pkg.sv
// types shared by the serial port slave
package i2csp_pkg;
	// slave sequencer states
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR2, ST_RX, ST_ACK, ST_TX, ST_TXACK} i2csp_state_t;
	// raw levels seen on the two bus lines
	typedef struct packed {
		logic scl;
		logic sda;
	} i2csp_pin_in_t;
	// open-drain drive of the two bus lines
	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} i2csp_pin_out_t;
endpackage : i2csp_pkg

//--- hw/i2csp_sync.sv
// two-stage line synchroniser with edge detection
`include "i2csp_map.svh"
module i2csp_sync #(
	parameter int WIDTH = 2
) (
	// clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// raw lines and sampled view
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);
	if (WIDTH < 1) begin : g_chk
		$error("WIDTH must be at least one");
	end
	// per line: catch stage, stable stage, history stage
	for (genvar i = 0; i < WIDTH; i++) begin : g_line
		logic meta;
		logic lv;
		logic prev;
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				meta <= `I2CSP_LINE_IDLE;
				lv   <= `I2CSP_LINE_IDLE;
				prev <= `I2CSP_LINE_IDLE;
			end else begin
				meta <= async_in[i];
				lv   <= meta;
				prev <= lv;
			end
		end
		// edges only from the stable stages
		assign level[i] = lv;
		assign rise[i]  = lv & ~prev;
		assign fall[i]  = ~lv & prev;
	end
endmodule // i2csp_sync

//--- hw/i2csp_top.sv
// two-wire serial port slave with register bus
`include "i2csp_map.svh"
module i2csp_top #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	// register bus
	input  wire logic                      hsel,
	input  wire logic [ADDR_W-1:0]         haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output logic                           hreadyout,
	output logic                           hresp,
	output logic      [31:0]               hrdata,
	// bus lines
	input  wire i2csp_pkg::i2csp_pin_in_t  pin_in,
	output i2csp_pkg::i2csp_pin_out_t      pin_out
);
	import i2csp_pkg::*;

	if (ADDR_W < 8) begin : g_chk
		$error("ADDR_W must be at least 8");
	end

	// software visible state
	logic [3:0]   mode;
	logic         en, clkrel, ov, bf, ua, rw, dna, s_flag, p_flag, pif;
	logic [7:0]   rbuf, addr_r, sr;
	logic [1:0]   pdir;
	// sequencer state
	i2csp_state_t st, ack_to, next_st;
	logic [3:0]   bitcnt, next_bitcnt;
	logic [7:0]   next_sr;
	logic         ack_drv, scl_hold, ten_full;
	// data phase of the bus
	logic         dp_wr;
	logic [7:0]   dp_ofs;
	// sampled lines
	logic [1:0]   lvl, rise, fall;

	i2csp_sync #(
		.WIDTH(2)
	) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.async_in({pin_in.scl, pin_in.sda}),
		.level   (lvl),
		.rise    (rise),
		.fall    (fall)
	);

	// line events
	wire scl_s     = lvl[1];
	wire sda_s     = lvl[0];
	wire scl_rise  = rise[1];
	wire scl_fall  = fall[1];
	wire start_evt = fall[0] && scl_s;
	wire stop_evt  = rise[0] && scl_s;

	// bus decode
	wire       ap     = hsel && hready && htrans[1];
	wire [7:0] ofs_a  = haddr[7:0];
	wire       rd_buf = ap && !hwrite && ofs_a == `I2CSP_OFS_BUF;
	wire       wr_ctl = dp_wr && dp_ofs == `I2CSP_OFS_CTRL;
	wire       wr_buf = dp_wr && dp_ofs == `I2CSP_OFS_BUF;
	wire       wr_adr = dp_wr && dp_ofs == `I2CSP_OFS_ADDR;
	wire       wr_dir = dp_wr && dp_ofs == `I2CSP_OFS_PDIR;
	wire       wr_pif = dp_wr && dp_ofs == `I2CSP_OFS_PIF;

	// register views and read selection
	wire [7:0] ctrl_v = {1'h0, ov, en, clkrel, mode};
	wire [7:0] stat_v = {2'h0, dna, p_flag, s_flag, rw, ua, bf};
	wire [7:0] rd_val = ofs_a == `I2CSP_OFS_CTRL ? ctrl_v :
		ofs_a == `I2CSP_OFS_STAT ? stat_v :
		ofs_a == `I2CSP_OFS_BUF  ? rbuf :
		ofs_a == `I2CSP_OFS_ADDR ? addr_r :
		ofs_a == `I2CSP_OFS_PDIR ? {6'h00, pdir} :
		ofs_a == `I2CSP_OFS_PIF  ? {7'h00, pif} : 8'h00;

	// mode decode
	wire s7     = en && (mode == `I2CSP_MODE_S7 || mode == `I2CSP_MODE_S7I);
	wire s10    = en && (mode == `I2CSP_MODE_S10 || mode == `I2CSP_MODE_S10I);
	wire mst    = en && mode == `I2CSP_MODE_MST;
	wire slv    = s7 || s10;
	wire ssint  = en && (mode == `I2CSP_MODE_S7I || mode == `I2CSP_MODE_S10I || mst);
	wire i2c_on = slv || mst;
	wire dir_in = &pdir;

	// byte completion and address match
	wire in_rx     = st == ST_ADDR || st == ST_ADDR2 || st == ST_RX;
	wire byte_done = scl_fall && in_rx && bitcnt == `I2CSP_BYTE_BITS;
	wire m7        = sr[7:1] == addr_r[7:1];
	wire hdr       = sr[7:3] == `I2CSP_TEN_HDR && m7;
	wire hit_a     = s7 ? m7 : hdr && (!sr[0] || ten_full);
	wire hit       = st == ST_RX || (st == ST_ADDR2 && sr == addr_r) || (st == ST_ADDR && hit_a);
	wire free      = !bf && !ov;
	wire accept    = byte_done && hit && free;
	wire set_ov    = byte_done && hit && bf;
	i2csp_state_t ack_next;
	assign ack_next = (st == ST_ADDR && s10 && !sr[0]) ? ST_ADDR2 :
		(st == ST_ADDR && sr[0]) ? ST_TX : ST_RX;

	// ninth clock and transmit events
	wire ack_end  = scl_fall && st == ST_ACK;
	wire txa_end  = scl_fall && st == ST_TXACK;
	wire enter_tx = (ack_end && ack_drv && ack_to == ST_TX) || txa_end;
	wire nack_tx  = scl_rise && st == ST_TXACK && sda_s;
	wire rel_req  = (wr_ctl && hwdata[`I2CSP_CTRL_CLKREL] && !ua) || (wr_adr && ua);
	wire set_pif  = ack_end || txa_end || ((start_evt || stop_evt) && ssint);

	// open-drain line drive
	wire sda_low = (slv && dir_in && (ack_drv || (st == ST_TX && !sr[7]))) ||
		(i2c_on && !pdir[`I2CSP_PDIR_SDA]);
	wire scl_low = (slv && dir_in && scl_hold) || (i2c_on && !pdir[`I2CSP_PDIR_SCL]);

	// sequencer next state
	always_comb begin
		next_st     = st;
		next_bitcnt = bitcnt;
		next_sr     = sr;
		if (!slv) begin
			next_st = ST_IDLE;
		end else if (start_evt) begin
			next_st     = ST_ADDR;
			next_bitcnt = 4'h0;
		end else if (stop_evt) begin
			next_st = ST_IDLE;
		end else begin
			case (st)
				ST_ADDR, ST_ADDR2, ST_RX: begin
					if (scl_rise) begin
						next_sr     = {sr[6:0], sda_s};
						next_bitcnt = bitcnt + 4'h1;
					end else if (byte_done) begin
						next_st = hit ? ST_ACK : ST_IDLE;
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						next_bitcnt = 4'h0;
						next_sr     = 8'hFF;
						next_st     = ack_drv ? ack_to : ST_IDLE;
					end
				end
				ST_TX: begin
					if (wr_buf) begin
						next_sr = hwdata[7:0];
					end else if (scl_fall) begin
						next_sr     = {sr[6:0], 1'h1};
						next_bitcnt = bitcnt + 4'h1;
						if (bitcnt == `I2CSP_LAST_BIT) begin
							next_st = ST_TXACK;
						end
					end
				end
				ST_TXACK: begin
					if (nack_tx) begin
						next_st = ST_IDLE;
					end else if (scl_fall) begin
						next_st     = ST_TX;
						next_bitcnt = 4'h0;
						next_sr     = 8'hFF;
					end
				end
				ST_IDLE: begin
					next_st = ST_IDLE;
				end
				default: begin
					next_st = ST_IDLE;
				end
			endcase
		end
	end

	// sequencer registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st     <= ST_IDLE;
			bitcnt <= 4'h0;
			sr     <= 8'h00;
			ack_to <= ST_IDLE;
		end else begin
			st     <= next_st;
			bitcnt <= next_bitcnt;
			sr     <= next_sr;
			if (byte_done) begin
				ack_to <= ack_next;
			end
		end
	end

	// acknowledge drive and clock hold
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ack_drv  <= 1'h0;
			scl_hold <= 1'h0;
		end else if (!slv || start_evt || stop_evt) begin
			ack_drv  <= 1'h0;
			scl_hold <= 1'h0;
		end else begin
			if (byte_done) begin
				ack_drv <= accept;
			end else if (ack_end) begin
				ack_drv <= 1'h0;
			end
			if (enter_tx || (ack_end && ack_drv && (ua || !clkrel))) begin
				scl_hold <= 1'h1;
			end else if (rel_req) begin
				scl_hold <= 1'h0;
			end
		end
	end

	// control, buffer and address registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode   <= 4'h0;
			en     <= 1'h0;
			clkrel <= 1'h0;
			ov     <= 1'h0;
			bf     <= 1'h0;
			rbuf   <= 8'h00;
			addr_r <= 8'h00;
			pdir   <= `I2CSP_RST_PDIR;
			pif    <= 1'h0;
		end else begin
			if (wr_ctl) begin
				mode <= hwdata[`I2CSP_MODE_HI:0];
				en   <= hwdata[`I2CSP_CTRL_EN];
			end
			clkrel <= enter_tx ? 1'h0 : (wr_ctl ? hwdata[`I2CSP_CTRL_CLKREL] : clkrel);
			ov     <= set_ov | (wr_ctl ? hwdata[`I2CSP_CTRL_OV] : ov);
			bf     <= accept | (bf & ~rd_buf);
			if (accept) begin
				rbuf <= sr;
			end else if (wr_buf) begin
				rbuf <= hwdata[7:0];
			end
			if (wr_adr) begin
				addr_r <= hwdata[7:0];
			end
			if (wr_dir) begin
				pdir <= hwdata[1:0];
			end
			pif <= set_pif | (wr_pif ? hwdata[`I2CSP_PIF_BIT] : pif);
		end
	end

	// status flags
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_flag   <= 1'h0;
			p_flag   <= 1'h0;
			rw       <= 1'h0;
			dna      <= 1'h0;
			ua       <= 1'h0;
			ten_full <= 1'h0;
		end else begin
			if (!en) begin
				s_flag <= 1'h0;
				p_flag <= 1'h0;
			end else if (start_evt) begin
				s_flag <= 1'h1;
				p_flag <= 1'h0;
			end else if (stop_evt) begin
				s_flag <= 1'h0;
				p_flag <= 1'h1;
			end
			if (nack_tx) begin
				rw  <= 1'h0;
				dna <= 1'h0;
			end else if (byte_done && hit) begin
				dna <= st == ST_RX;
				if (st == ST_ADDR) begin
					rw <= sr[0];
				end
			end
			if (byte_done && hit && s10 && (st == ST_ADDR2 || ack_next == ST_ADDR2)) begin
				ua <= 1'h1;
			end else if (wr_adr || !slv) begin
				ua <= 1'h0;
			end
			if (!slv || stop_evt) begin
				ten_full <= 1'h0;
			end else if (byte_done && hit && st == ST_ADDR2) begin
				ten_full <= 1'h1;
			end
		end
	end

	// bus slave and line outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'h1;
			hresp     <= `I2CSP_HRESP_OKAY;
			hrdata    <= 32'h0000_0000;
			dp_wr     <= 1'h0;
			dp_ofs    <= 8'h00;
			pin_out   <= '0;
		end else begin
			hreadyout <= 1'h1;
			hresp     <= `I2CSP_HRESP_OKAY;
			dp_wr     <= ap && hwrite;
			dp_ofs    <= ofs_a;
			if (ap && !hwrite) begin
				hrdata <= {24'h000000, rd_val};
			end
			pin_out.scl_o  <= 1'h0;
			pin_out.sda_o  <= 1'h0;
			pin_out.scl_oe <= scl_low;
			pin_out.sda_oe <= sda_low;
		end
	end

	// checks
	property p_start_flag;
		@(posedge hclk) disable iff (!hresetn) en && start_evt |=> s_flag && !p_flag;
	endproperty
	a_start_flag: assert property (p_start_flag) else $error("start not flagged");
	property p_stop_flag;
		@(posedge hclk) disable iff (!hresetn) en && stop_evt |=> p_flag && !s_flag && st == ST_IDLE;
	endproperty
	a_stop_flag: assert property (p_stop_flag) else $error("stop not flagged");
	property p_sda_low_clk;
		@(posedge hclk) disable iff (!hresetn)
		slv && dir_in && $stable(mode) && $changed(pin_out.sda_oe) |-> !$past(scl_s, 2);
	endproperty
	a_sda_low_clk: assert property (p_sda_low_clk) else $error("data moved with clock high");
	property p_ack_drive;
		@(posedge hclk) disable iff (!hresetn) accept && dir_in |=> ack_drv ##1 pin_out.sda_oe;
	endproperty
	a_ack_drive: assert property (p_ack_drive) else $error("accepted byte not acknowledged");
	property p_refused;
		@(posedge hclk) disable iff (!hresetn) byte_done && !accept && dir_in |=> !ack_drv ##1 !pin_out.sda_oe;
	endproperty
	a_refused: assert property (p_refused) else $error("refused byte drives data");
	property p_tx_nack;
		@(posedge hclk) disable iff (!hresetn) slv && nack_tx && !stop_evt |=> st == ST_IDLE && !rw;
	endproperty
	a_tx_nack: assert property (p_tx_nack) else $error("no reset after final no-ack");
	sequence s_held;
		scl_hold && !clkrel ##1 pin_out.scl_oe;
	endsequence
	property p_tx_stretch;
		@(posedge hclk) disable iff (!hresetn) slv && dir_in && enter_tx |=> s_held;
	endproperty
	a_tx_stretch: assert property (p_tx_stretch) else $error("transmit did not stretch");
	property p_start_pif;
		@(posedge hclk) disable iff (!hresetn) ssint && (start_evt || stop_evt) |=> pif;
	endproperty
	a_start_pif: assert property (p_start_pif) else $error("start or stop flag missing");
	property p_off_quiet;
		@(posedge hclk) disable iff (!hresetn) !en |=> !pin_out.scl_oe && !pin_out.sda_oe && st == ST_IDLE;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("disabled port active");
	property p_load;
		@(posedge hclk) disable iff (!hresetn) accept |=> bf && rbuf == $past(sr);
	endproperty
	a_load: assert property (p_load) else $error("byte not buffered");
	property p_overflow;
		@(posedge hclk) disable iff (!hresetn) set_ov && !wr_buf |=> ov && $stable(rbuf);
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not handled");
	property p_rd_clear;
		@(posedge hclk) disable iff (!hresetn) rd_buf && !accept |=> !bf;
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("read kept buffer full");
	property p_master_idle;
		@(posedge hclk) disable iff (!hresetn) mst && start_evt |=> st == ST_IDLE ##1 st == ST_IDLE;
	endproperty
	a_master_idle: assert property (p_master_idle) else $error("slave ran in master mode");
endmodule // i2csp_top

//--- tb/i2csp_master_model.sv
// two-wire bus master model that drives the far side of the slave
module i2csp_master_model (
	// wired line levels
	input  wire logic scl,
	input  wire logic sda,
	// open-drain pulls, high pulls the line low
	output logic      scl_oe,
	output logic      sda_oe,
	// set when a clock stretch outlasts the bound
	output logic      hung
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int QTR = 16; // quarter of the 64 ns link period
	// idle bus, nothing pulled, clock stands still
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
		hung   = 1'b0;
	end
	// release clock, wait out any stretch, high phase timed from the real rise
	task automatic clk_up();
		int k;
		scl_oe <= 1'b0;
		#1;
		for (k = 0; k < 4000 && scl !== 1'b1; k++) #1;
		if (scl !== 1'b1) hung = 1'b1;
	endtask
	// one bit: data moves mid-low, sampled mid-high
	task automatic bit_x(input logic b, output logic r);
		#QTR sda_oe <= !b;
		#QTR clk_up();
		#QTR r = sda;
		#QTR scl_oe <= 1'b1;
	endtask
	// start from idle, or repeated start after an acknowledge
	task automatic do_start();
		#QTR sda_oe <= 1'b0;
		#QTR clk_up();
		#QTR sda_oe <= 1'b1;
		#QTR scl_oe <= 1'b1;
	endtask
	// stop: data rises while the clock is high
	task automatic do_stop();
		#QTR sda_oe <= 1'b1;
		#QTR clk_up();
		#QTR sda_oe <= 1'b0;
		#QTR;
	endtask
	// send a byte msb first, drop the data drive once arbitration is lost
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic r;
		logic lost;
		lost = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i] | lost, r);
			lost = lost | (r !== (d[i] | lost));
		end
		bit_x(1'b1, r);
		ack = !r;
	endtask
	// receive a byte, acknowledge all but the last
	task automatic get_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(last, r);
	endtask
endmodule // i2csp_master_model

//--- tb/i2c_slave_serial_port_tb_top.sv
// self-checking bench of the two-wire serial port slave
`include "i2csp_map.svh"
`define I2CSP_CMP(g, e, m) begin \
	n_tests++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("mismatch %0t %s got %h exp %h", $time, m, (g), (e)); \
	end \
end
module i2c_slave_serial_port_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import i2csp_pkg::*;
	localparam logic [7:0] CTL = `I2CSP_OFS_CTRL;
	localparam logic [7:0] STA = `I2CSP_OFS_STAT;
	localparam logic [7:0] BUF = `I2CSP_OFS_BUF;
	localparam logic [7:0] ADR = `I2CSP_OFS_ADDR;
	localparam logic [7:0] DIR = `I2CSP_OFS_PDIR;
	localparam logic [7:0] PIF = `I2CSP_OFS_PIF;
	// bus and line signals
	logic           hclk    = 1'b0;
	logic           hresetn = 1'b0;
	logic [7:0]     haddr   = 8'h00;
	logic [1:0]     htrans  = 2'h0;
	logic           hwrite  = 1'b0;
	logic [31:0]    hwdata  = 32'h0;
	logic           hreadyout;
	logic           hresp;
	logic [31:0]    hrdata;
	i2csp_pin_in_t  pin_in;
	i2csp_pin_out_t pin_out;
	logic           m_scl_oe;
	logic           m_sda_oe;
	logic           m_hung;
	logic [31:0]    rd;
	logic [7:0]     byt;
	logic           ack;
	int             error_cnt = 0;
	int             n_tests   = 0;
	logic [7:0]     ofs [7] = '{CTL, STA, BUF, ADR, DIR, PIF, 8'h18};
	logic [31:0]    rv [7]  = '{32'h0, 32'h0, 32'h0, 32'h0, {30'h0, `I2CSP_RST_PDIR}, 32'h0, 32'h0};
	logic [3:0]     md [4]  = '{`I2CSP_MODE_S7I, `I2CSP_MODE_S10I, `I2CSP_MODE_MST, `I2CSP_MODE_S7};
	logic [31:0]    fl [4]  = '{32'h1, 32'h1, 32'h1, 32'h0};
	// 200 MHz clock
	always #2.5 hclk = ~hclk;
	// wired-and lines with pull-ups
	assign pin_in.scl = !(pin_out.scl_oe | m_scl_oe);
	assign pin_in.sda = !(pin_out.sda_oe | m_sda_oe);
	i2csp_top u_dut (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (1'b1),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (3'h2),
		.hwdata    (hwdata),
		.hready    (hreadyout),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.pin_in    (pin_in),
		.pin_out   (pin_out)
	);
	i2csp_master_model u_mst (
		.scl    (pin_in.scl),
		.sda    (pin_in.sda),
		.scl_oe (m_scl_oe),
		.sda_oe (m_sda_oe),
		.hung   (m_hung)
	);
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// a stretch that never ends cuts the run short
	always @(posedge m_hung) begin
		error_cnt++;
		tally_and_finish();
	end
	// wait for hready at a rising edge, bounded
	task automatic hrdy();
		int k;
		for (k = 0; k < 16; k++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1) break;
		end
		if (k == 16) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask
	// one single word transfer: address phase, then data phase
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hrdy();
		htrans <= 2'h0;
		hwdata <= d;
		hrdy();
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(a, 1'b1, d, q);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m, input logic [31:0] k = 32'hFFFFFFFF);
		xfer(a, 1'b0, 32'h0, rd);
		`I2CSP_CMP(rd & k, e, m)
		`I2CSP_CMP(hresp, `I2CSP_HRESP_OKAY, "resp")
	endtask
	task automatic snd(input logic [7:0] d, input logic e, input string m);
		u_mst.put_byte(d, ack);
		`I2CSP_CMP(ack, e, m)
	endtask
	// clock pull after a settle time; the driven levels must stay low
	task automatic held(input logic e, input string m);
		repeat (10) @(posedge hclk);
		`I2CSP_CMP(pin_out.scl_oe, e, m)
		`I2CSP_CMP({pin_out.scl_o, pin_out.sda_o}, 2'h0, "open drain")
	endtask
	// main sequence
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (ofs[i]) rchk(ofs[i], rv[i], "reset");
		wr(STA, 32'hFF);
		rchk(STA, 32'h0, "ro stat");
		// port disabled: no answer
		wr(ADR, 32'hA4);
		wr(CTL, 32'h16);
		u_mst.do_start();
		snd(8'hA4, 1'b0, "off");
		u_mst.do_stop();
		rchk(STA, 32'h0, "off stat");
		// seven-bit receive, then overflow
		wr(CTL, 32'h36);
		u_mst.do_start();
		snd(8'hA4, 1'b1, "adr ack");
		rchk(STA, 32'h09, "adr stat");
		rchk(PIF, 32'h1, "flag");
		rchk(BUF, 32'hA4, "adr buf");
		rchk(STA, 32'h08, "bf clr");
		wr(PIF, 32'h0);
		snd(8'h5A, 1'b1, "dat ack");
		rchk(STA, 32'h29, "dat stat");
		snd(8'h3C, 1'b0, "ovf nack");
		rchk(CTL, 32'h76, "ovf");
		rchk(BUF, 32'h5A, "kept");
		u_mst.do_stop();
		rchk(STA, 32'h10, "stop", 32'h10);
		rchk(CTL, 32'h76, "ovf sticky");
		wr(CTL, 32'h36);
		rchk(CTL, 32'h36, "ovf clr");
		// wrong address, then pins not both inputs
		u_mst.do_start();
		snd(8'hA6, 1'b0, "miss");
		u_mst.do_stop();
		// a cleared direction bit pulls data low; changed only while the master holds the clock low
		u_mst.do_start();
		wr(DIR, 32'h1);
		repeat (10) @(posedge hclk);
		`I2CSP_CMP(pin_out.sda_oe, 1'b1, "dir")
		wr(DIR, 32'h3);
		u_mst.do_stop();
		// receive stretch while clock release is clear
		wr(CTL, 32'h26);
		u_mst.do_start();
		snd(8'hA4, 1'b1, "rx adr");
		held(1'b1, "rx hold");
		rchk(BUF, 32'hA4, "rx buf");
		fork
			snd(8'h11, 1'b1, "late");
			begin
				repeat (30) @(posedge hclk);
				`I2CSP_CMP(pin_in.scl, 1'b0, "wait")
				wr(CTL, 32'h36);
			end
		join
		rchk(BUF, 32'h11, "rx dat");
		u_mst.do_stop();
		// seven-bit transmit, master ends with no acknowledge
		u_mst.do_start();
		snd(8'hA5, 1'b1, "tx adr");
		held(1'b1, "tx hold");
		rchk(STA, 32'h0D, "tx stat");
		rchk(BUF, 32'hA5, "tx buf");
		wr(BUF, 32'hC3);
		wr(CTL, 32'h36);
		u_mst.get_byte(1'b0, byt);
		`I2CSP_CMP(byt, 8'hC3, "tx 1")
		held(1'b1, "tx hold2");
		wr(BUF, 32'h81);
		wr(CTL, 32'h36);
		u_mst.get_byte(1'b1, byt);
		`I2CSP_CMP(byt, 8'h81, "tx 2")
		repeat (8) @(posedge hclk);
		`I2CSP_CMP(pin_out.sda_oe, 1'b0, "tx rel")
		u_mst.do_stop();
		// ten-bit write, then repeated start and read
		wr(CTL, 32'h37);
		wr(ADR, 32'hF2);
		u_mst.do_start();
		snd(8'hF2, 1'b1, "hdr");
		rchk(STA, 32'h2, "ua", 32'h2);
		rchk(BUF, 32'hF2, "hdr buf");
		wr(ADR, 32'h35);
		snd(8'h35, 1'b1, "low");
		rchk(BUF, 32'h35, "low buf");
		wr(ADR, 32'hF2);
		snd(8'h77, 1'b1, "10 dat");
		rchk(BUF, 32'h77, "10 buf");
		u_mst.do_start();
		snd(8'hF3, 1'b1, "rs hdr");
		rchk(BUF, 32'hF3, "rs buf");
		wr(BUF, 32'hE7);
		wr(CTL, 32'h37);
		u_mst.get_byte(1'b1, byt);
		`I2CSP_CMP(byt, 8'hE7, "rs tx")
		u_mst.do_stop();
		// start and stop flag per mode
		foreach (md[i]) begin
			wr(CTL, {28'h3, md[i]});
			wr(PIF, 32'h0);
			u_mst.do_start();
			u_mst.do_stop();
			rchk(PIF, fl[i], "mode flag");
		end
		// firmware master mode: slave idle, direction pulls the clock
		wr(CTL, 32'h3B);
		u_mst.do_start();
		snd(8'hA4, 1'b0, "mst idle");
		u_mst.do_stop();
		wr(DIR, 32'h2);
		held(1'b1, "mst pull");
		wr(DIR, 32'h3);
		held(1'b0, "mst rel");
		tally_and_finish();
	end
endmodule // i2c_slave_serial_port_tb_top
